// File: acrb_cfg.svh
// acrb_cfg.svh: addresses, field positions, reset values of the config bank
// assumes: included by bare name from the bank and divider sources
`ifndef ACRB_CFG_SVH
`define ACRB_CFG_SVH

// register addresses
`define ACRB_ADDR_PORT   8'h00
`define ACRB_ADDR_ID     8'h01
`define ACRB_ADDR_GRADE  8'h02
`define ACRB_ADDR_CHSEL  8'h05
`define ACRB_ADDR_PWR    8'h08
`define ACRB_ADDR_STAB   8'h09
`define ACRB_ADDR_DIV    8'h0B
`define ACRB_ADDR_XFER   8'hFF

// field positions
`define ACRB_LSB_HI      6
`define ACRB_LSB_LO      1
`define ACRB_SRST_HI     5
`define ACRB_SRST_LO     2
`define ACRB_PIN_FN_BIT  5
`define ACRB_XFER_BIT    0
`define ACRB_PHASE_LSB   3
`define ACRB_GRADE_LSB   4

// reset values
`define ACRB_RST_PORT    8'h18
`define ACRB_RST_CHSEL   2'h3
`define ACRB_RST_PIN_FN  1'h0
`define ACRB_RST_STAB    1'h1
`define ACRB_RST_RATIO   3'h0
`define ACRB_RST_PHASE   3'h0

`endif

// File: acrb_pkg.sv
// acrb_pkg.sv: types shared by the config bank and its clock divider
// assumes: nothing beyond a SystemVerilog compiler
package acrb_pkg;
    // per-channel power mode field
    typedef enum logic [1:0] {
        acrb_pm_normal  = 2'h0,
        acrb_pm_down    = 2'h1,
        acrb_pm_standby = 2'h2,
        acrb_pm_spare   = 2'h3
    } acrb_pm_t;
    // divide ratio and phase delay codes
    typedef logic [2:0] acrb_div_t;
endpackage : acrb_pkg

// File: acrb_clk_div.sv
// acrb_clk_div.sv: input clock divider, emits a one-cycle enable
// assumes: ratio and phase stay steady between load pulses
`include "acrb_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module acrb_clk_div
    import acrb_pkg::*;
(
    input  wire logic      clk_in,
    input  wire logic      rst_in,
    input  wire logic      load_in,
    input  wire acrb_div_t ratio_in,
    input  wire acrb_div_t phase_in,
    output var  logic      en_out
);
    acrb_div_t cnt;   // position inside one divided period
    acrb_div_t dly;   // phase delay still to run

    // delay by phase, then pulse once every ratio plus one cycles
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt    <= 3'h0;
            dly    <= 3'h0;
            en_out <= 1'b0;
        end else if (load_in) begin
            // restart so that new settings take hold from a known phase
            cnt    <= 3'h0;
            dly    <= phase_in;
            en_out <= 1'b0;
        end else if (dly != 3'h0) begin
            dly    <= dly - 3'h1;
            en_out <= 1'b0;
        end else begin
            en_out <= (cnt == 3'h0);
            cnt    <= (cnt == ratio_in) ? 3'h0 : cnt + 3'h1;
        end
    end

    // divide by two spaces enables two cycles apart
    div_two_a: // [R11]
        assert property (@(posedge clk_in) disable iff (rst_in)
            (en_out && ratio_in == 3'h1 && !load_in) ##1 !load_in
            |-> !en_out ##1 en_out)
        else $error("divide by two enable spacing wrong");
endmodule : acrb_clk_div
`default_nettype wire

// File: acrb_reg_bank.sv
// acrb_reg_bank.sv: configuration register bank of a dual converter
// assumes: serial framing logic on clk_in drives the word-wide access port
//
// Function
// R1 - unmapped addresses and bits ignored, read zero
// R2 - port setup resets 0x18, fixed bits
// R3 - shift order and soft reset mirrored
// R4 - channel select resets 0x03, picks targets
// R5 - chip-wide registers ignore channel select
// R6 - pin function bit picks power-down or standby
// R7 - shadowed registers act only on transfer
// R8 - writing transfer applies all, bit autoclears
// R9 - both selected: write both, read A
// R10 - soft reset reloads default values
// R11 - divider ratio, phase; nonzero ratio forces stabilizer
`include "acrb_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module acrb_reg_bank
    import acrb_pkg::*;
#(
    parameter logic [7:0] PART_IDENTIFIER     = 8'h5A,  // arbitrary identity value
    parameter logic [1:0] SPEED_GRADE = 2'h0    // grade code read back
) (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    input  wire logic [7:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       pwdn_pin_in,
    output var  logic [7:0] reg_rdata_out,
    output var  logic       reg_rvalid_out,
    output var  logic       lsb_first_out,
    output var  logic [1:0] power_down_out,
    output var  logic [1:0] standby_out,
    output var  logic       duty_cycle_stabilizer_out,
    output logic            div_clk_en_out
);
    logic       lsb_first;        // shift order, mirrored at bits 6 and 1
    logic [1:0] chan_sel;         // bit 0 channel A, bit 1 channel B
    acrb_pm_t   pm_shadow [2];    // power mode as written
    acrb_pm_t   pm_act    [2];    // power mode in effect
    logic [1:0] pfn_shadow;       // pin function as written
    logic [1:0] pfn_act;          // pin function in effect
    logic       dcs_shadow;       // stabilizer enable as written
    logic       dcs_act;          // stabilizer enable in effect
    acrb_div_t  ratio_shadow;     // divide ratio as written
    acrb_div_t  ratio_act;        // divide ratio in effect
    acrb_div_t  phase_shadow;     // phase delay as written
    acrb_div_t  phase_act;        // phase delay in effect
    logic       xfer_bit;         // transfer flag, clears itself
    logic       div_load;         // restarts divider after an update
    logic       pwdn_meta;        // pin synchroniser first stage
    logic       pwdn_sync;        // pin synchroniser second stage
    logic [7:0] next_rdata;       // read mux result
    logic       rd_ch;            // channel whose local value is read

    // access decode
    wire wr_port  = reg_wr_in && reg_addr_in == `ACRB_ADDR_PORT;
    wire wr_chsel = reg_wr_in && reg_addr_in == `ACRB_ADDR_CHSEL;
    wire wr_pwr   = reg_wr_in && reg_addr_in == `ACRB_ADDR_PWR;
    wire wr_stab  = reg_wr_in && reg_addr_in == `ACRB_ADDR_STAB;
    wire wr_div   = reg_wr_in && reg_addr_in == `ACRB_ADDR_DIV;
    // either mirrored soft reset bit starts a reload
    wire soft_req = wr_port && (reg_wdata_in[`ACRB_SRST_HI] ||
                                reg_wdata_in[`ACRB_SRST_LO]);   // [R3]
    wire xfer_req = reg_wr_in && reg_addr_in == `ACRB_ADDR_XFER &&
                    reg_wdata_in[`ACRB_XFER_BIT];               // [R8]
    wire mapped   = reg_addr_in == `ACRB_ADDR_PORT  ||
                    reg_addr_in == `ACRB_ADDR_ID    ||
                    reg_addr_in == `ACRB_ADDR_GRADE ||
                    reg_addr_in == `ACRB_ADDR_CHSEL ||
                    reg_addr_in == `ACRB_ADDR_PWR   ||
                    reg_addr_in == `ACRB_ADDR_STAB  ||
                    reg_addr_in == `ACRB_ADDR_DIV   ||
                    reg_addr_in == `ACRB_ADDR_XFER;

    // port setup: shift order, soft reset reloads default
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            lsb_first <= 1'b0;
        end else if (soft_req) begin
            lsb_first <= 1'b0;                                  // [R10]
        end else if (wr_port) begin
            // either copy of the bit sets it, so both orders decode alike
            lsb_first <= reg_wdata_in[`ACRB_LSB_HI] ||
                         reg_wdata_in[`ACRB_LSB_LO];            // [R3]
        end
    end

    // channel select, chip-wide and not shadowed
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            chan_sel <= `ACRB_RST_CHSEL;                        // [R4]
        end else if (soft_req) begin
            chan_sel <= `ACRB_RST_CHSEL;                        // [R10]
        end else if (wr_chsel) begin
            chan_sel <= reg_wdata_in[1:0];                      // [R4]
        end
    end

    // per-channel shadow and active power settings
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        // shadow copy written only when this channel is selected
        always_ff @(posedge clk_in or posedge rst_in) begin
            if (rst_in) begin
                pm_shadow[ch]  <= acrb_pm_normal;
                pfn_shadow[ch] <= `ACRB_RST_PIN_FN;
            end else if (soft_req) begin
                pm_shadow[ch]  <= acrb_pm_normal;               // [R10]
                pfn_shadow[ch] <= `ACRB_RST_PIN_FN;
            end else if (wr_pwr && chan_sel[ch]) begin          // [R4] [R9]
                pm_shadow[ch]  <= acrb_pm_t'(reg_wdata_in[1:0]);
                pfn_shadow[ch] <= reg_wdata_in[`ACRB_PIN_FN_BIT];
            end
        end
        // active copy follows shadow only on transfer
        always_ff @(posedge clk_in or posedge rst_in) begin
            if (rst_in) begin
                pm_act[ch]  <= acrb_pm_normal;
                pfn_act[ch] <= `ACRB_RST_PIN_FN;
            end else if (soft_req) begin
                pm_act[ch]  <= acrb_pm_normal;                  // [R10]
                pfn_act[ch] <= `ACRB_RST_PIN_FN;
            end else if (xfer_req) begin
                pm_act[ch]  <= pm_shadow[ch];                   // [R7] [R8]
                pfn_act[ch] <= pfn_shadow[ch];
            end
        end
        // pin asserted: clear bit gives power-down, set bit standby
        always_ff @(posedge clk_in or posedge rst_in) begin
            if (rst_in) begin
                power_down_out[ch] <= 1'b0;
                standby_out[ch]    <= 1'b0;
            end else begin
                power_down_out[ch] <= pm_act[ch] == acrb_pm_down ||
                                      (pwdn_sync && !pfn_act[ch]);  // [R6]
                standby_out[ch]    <= pm_act[ch] != acrb_pm_down &&
                                      (pm_act[ch] == acrb_pm_standby ||
                                       (pwdn_sync && pfn_act[ch])); // [R6]
            end
        end
    end

    // chip-wide shadows, written whatever the channel select
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            dcs_shadow   <= `ACRB_RST_STAB;
            ratio_shadow <= `ACRB_RST_RATIO;
            phase_shadow <= `ACRB_RST_PHASE;
        end else if (soft_req) begin
            dcs_shadow   <= `ACRB_RST_STAB;                     // [R10]
            ratio_shadow <= `ACRB_RST_RATIO;
            phase_shadow <= `ACRB_RST_PHASE;
        end else begin
            if (wr_stab) begin
                dcs_shadow <= reg_wdata_in[0];                  // [R5]
            end
            if (wr_div) begin
                ratio_shadow <= reg_wdata_in[2:0];              // [R11]
                phase_shadow <= reg_wdata_in[`ACRB_PHASE_LSB +: 3];
            end
        end
    end

    // chip-wide active copies, loaded together on transfer
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            dcs_act   <= `ACRB_RST_STAB;
            ratio_act <= `ACRB_RST_RATIO;
            phase_act <= `ACRB_RST_PHASE;
        end else if (soft_req) begin
            dcs_act   <= `ACRB_RST_STAB;                        // [R10]
            ratio_act <= `ACRB_RST_RATIO;
            phase_act <= `ACRB_RST_PHASE;
        end else if (xfer_req) begin
            dcs_act   <= dcs_shadow;                            // [R7] [R8]
            ratio_act <= ratio_shadow;
            phase_act <= phase_shadow;
        end
    end

    // transfer flag: set for one cycle, then clears itself
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            xfer_bit <= 1'b0;
            div_load <= 1'b0;
        end else begin
            xfer_bit <= xfer_req;                               // [R8]
            div_load <= xfer_req || soft_req;
        end
    end

    // power-down pin crosses in through two flip-flops
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pwdn_meta <= 1'b0;
            pwdn_sync <= 1'b0;
        end else begin
            pwdn_meta <= pwdn_pin_in;
            pwdn_sync <= pwdn_meta;
        end
    end

    // stabilizer output, forced on by any division
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            duty_cycle_stabilizer_out <= `ACRB_RST_STAB;
            lsb_first_out             <= 1'b0;
        end else begin
            duty_cycle_stabilizer_out <= dcs_act ||
                                         ratio_act != 3'h0;     // [R11]
            lsb_first_out             <= lsb_first;
        end
    end

    // read mux: local reads favour channel A when both selected
    always_comb begin
        rd_ch = !chan_sel[0] && chan_sel[1];                    // [R9]
        unique case (reg_addr_in)
            `ACRB_ADDR_PORT: begin
                next_rdata = `ACRB_RST_PORT;                    // [R2]
                next_rdata[`ACRB_LSB_HI] = lsb_first;           // [R3]
                next_rdata[`ACRB_LSB_LO] = lsb_first;
            end
            `ACRB_ADDR_ID:    next_rdata = PART_IDENTIFIER;
            `ACRB_ADDR_GRADE: begin
                next_rdata = 8'h00;
                next_rdata[`ACRB_GRADE_LSB +: 2] = SPEED_GRADE;
            end
            `ACRB_ADDR_CHSEL: next_rdata = {6'h00, chan_sel};
            `ACRB_ADDR_PWR:   begin
                next_rdata = {6'h00, pm_shadow[rd_ch]};
                next_rdata[`ACRB_PIN_FN_BIT] = pfn_shadow[rd_ch];
            end
            `ACRB_ADDR_STAB:  next_rdata = {7'h00, dcs_shadow};
            `ACRB_ADDR_DIV:   next_rdata = {2'h0, phase_shadow,
                                            ratio_shadow};
            `ACRB_ADDR_XFER:  next_rdata = {7'h00, xfer_bit};
            default:          next_rdata = 8'h00;               // [R1]
        endcase
    end

    // read data registered one cycle after the strobe
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            reg_rdata_out  <= 8'h00;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_rd_in;
            if (reg_rd_in) begin
                reg_rdata_out <= next_rdata;
            end
        end
    end

    // divider runs from the active ratio and phase
    acrb_clk_div u_div (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .load_in  (div_load),
        .ratio_in (ratio_act),
        .phase_in (phase_act),
        .en_out   (div_clk_en_out)
    );

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    unmapped_zero_a: // [R1]
        assert property (reg_rd_in && !mapped |=> reg_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    port_fixed_a: // [R2]
        assert property (reg_rd_in && reg_addr_in == `ACRB_ADDR_PORT
            |=> reg_rdata_out[7] == 1'b0 && reg_rdata_out[0] == 1'b0
                && reg_rdata_out[4:3] == 2'h3)
        else $error("port setup fixed bits wrong");
    port_mirror_a: // [R3]
        assert property (reg_rd_in && reg_addr_in == `ACRB_ADDR_PORT
            |=> reg_rdata_out[6] == reg_rdata_out[1]
                && reg_rdata_out[5:2] == 4'h6)
        else $error("port setup not mirrored");
    chan_steer_a: // [R4]
        assert property (wr_pwr && chan_sel == 2'h2
            |=> $stable(pm_shadow[0]) && pm_shadow[1] ==
                acrb_pm_t'($past(reg_wdata_in[1:0])))
        else $error("channel select steering wrong");
    global_write_a: // [R5]
        assert property (wr_stab && chan_sel == 2'h0
            |=> dcs_shadow == $past(reg_wdata_in[0]))
        else $error("chip-wide write gated by channel");
    pin_standby_a: // [R6]
        assert property (pwdn_sync && pfn_act[0] &&
            pm_act[0] == acrb_pm_normal
            |=> standby_out[0] && !power_down_out[0])
        else $error("pin function not standby");
    shadow_hold_a: // [R7]
        assert property (!xfer_req && !soft_req
            |=> $stable(pm_act[1]) && $stable(dcs_act)
                && $stable(ratio_act) && $stable(pfn_act))
        else $error("active value moved without transfer");
    xfer_apply_a: // [R8]
        assert property (xfer_req ##1 !xfer_req
            |-> pm_act[0] == $past(pm_shadow[0]) && xfer_bit
                && ratio_act == $past(ratio_shadow) ##1 !xfer_bit)
        else $error("transfer did not apply or clear");
    both_read_a: // [R9]
        assert property (reg_rd_in && reg_addr_in == `ACRB_ADDR_PWR &&
            chan_sel == 2'h3
            |=> reg_rdata_out[1:0] == $past(pm_shadow[0]))
        else $error("both selected read not channel A");
    soft_reload_a: // [R10]
        assert property (soft_req
            |=> !lsb_first && chan_sel == `ACRB_RST_CHSEL && dcs_act
                && ratio_act == 3'h0 ##1 !lsb_first_out)
        else $error("soft reset did not reload");
    dcs_force_a: // [R11]
        assert property (ratio_act != 3'h0 |=> duty_cycle_stabilizer_out)
        else $error("divide ratio did not force stabilizer");

    xfer_seen_c: cover property (xfer_req);
    soft_seen_c: cover property (soft_req ##1 reg_rd_in);
    both_wr_c:   cover property (wr_pwr && chan_sel == 2'h3);
    pin_down_c:  cover property (pwdn_sync && |power_down_out);
endmodule : acrb_reg_bank
`default_nettype wire

// File: acrb_host_model.sv
// acrb_host_model.sv: host side of the word-wide register access port
// assumes: tasks are entered just after a rising clk_in edge
`timescale 1ns/10ps
`default_nettype none
module acrb_host_model (
    input  wire logic       clk_in,        // bank clock
    input  wire logic [7:0] reg_rdata_in,  // read data from the bank
    input  wire logic       reg_rvalid_in, // read data valid pulse
    output var  logic       reg_wr_out,    // write strobe
    output var  logic       reg_rd_out,    // read strobe
    output var  logic [7:0] reg_addr_out,  // register address
    output var  logic [7:0] reg_wdata_out  // write data
);
    // idle bus at time zero
    initial begin
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
        reg_addr_out = 8'h00;
        reg_wdata_out = 8'h00;
    end

    // bus idle: strobes down, lines show the inverse of their last value
    task automatic idle();
        if (reg_wr_out || reg_rd_out) begin
            reg_wr_out = 1'b0;
            reg_rd_out = 1'b0;
            reg_addr_out = ~reg_addr_out;
            reg_wdata_out = ~reg_wdata_out;
        end
    endtask : idle

    // one write; strobe stays up until the next call or idle, so
    // back to back accesses never touch a line twice in one step
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        reg_rd_out = 1'b0;
        reg_wr_out = 1'b1;
        reg_addr_out = a;
        reg_wdata_out = d;
        @(posedge clk_in);
        #1;
    endtask : wr_reg

    // one read, then a bounded wait for the valid pulse
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d,
                          output logic ok);
        ok = 1'b0;
        d = 8'h00;
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b1;
        reg_addr_out = a;
        @(posedge clk_in);
        #1;
        // strobe held: repeated reads have no side effect
        for (int i = 0; i < 4 && !ok; i++) begin
            if (reg_rvalid_in === 1'b1) begin
                d = reg_rdata_in;
                ok = 1'b1;
            end else begin
                @(posedge clk_in);
                #1;
            end
        end
    endtask : rd_reg
endmodule : acrb_host_model
`default_nettype wire

// File: adc_config_register_bank_tb.sv
// adc_config_register_bank_tb.sv: self-checking bench of the config bank
// assumes: host model drives the access port, bench drives the pin
`timescale 1ns/10ps
`default_nettype none
module adc_config_register_bank_tb;
    localparam logic [7:0] ID_VAL = 8'h3C; // arbitrary identity value
    localparam logic [1:0] GRADE  = 2'h1;  // grade code under test
    localparam logic [7:0] RA [8] = '{8'h00, 8'h01, 8'h02, 8'h05,
                                      8'h08, 8'h09, 8'h0B, 8'hFF};
    localparam logic [7:0] RV [8] = '{8'h18, ID_VAL, {2'h0, GRADE, 4'h0},
                                      8'h03, 8'h00, 8'h01, 8'h00, 8'h00};
    logic       clk_in;    // bench clock
    logic       rst_in;    // async reset
    logic       pwdn_pin;  // external power-down pin
    wire  logic wr;        // write strobe
    wire  logic rd;        // read strobe
    wire  logic [7:0] addr;
    wire  logic [7:0] wdata;
    wire  logic [7:0] rdata;
    wire  logic rvalid;
    wire  logic lsb;       // shift order level
    wire  logic [1:0] pd;  // per channel power-down
    wire  logic [1:0] sb;  // per channel standby
    wire  logic stab;      // stabilizer active
    wire  logic div_en;    // divided clock enable
    int         err_count;
    int         checks_done;
    int         g;

    acrb_reg_bank #(.PART_IDENTIFIER(ID_VAL), .SPEED_GRADE(GRADE)) u_acrb_reg_bank (
        .clk_in(clk_in), .rst_in(rst_in), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .pwdn_pin_in(pwdn_pin),
        .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
        .lsb_first_out(lsb), .power_down_out(pd), .standby_out(sb),
        .duty_cycle_stabilizer_out(stab), .div_clk_en_out(div_en));

    acrb_host_model u_acrb_host_model (
        .clk_in(clk_in), .reg_rdata_in(rdata), .reg_rvalid_in(rvalid),
        .reg_wr_out(wr), .reg_rd_out(rd), .reg_addr_out(addr),
        .reg_wdata_out(wdata));

    // 250 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end

    // verdict and end of run
    task automatic finish_test();
        $display("errors %0d checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test

    // release the bus, wait n edges, then step off the edge
    task automatic step(input int n);
        u_acrb_host_model.idle();
        repeat (n) @(posedge clk_in);
        #1;
    endtask : step

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        u_acrb_host_model.wr_reg(a, d);
    endtask : wr_reg

    // read a register and compare with the expected byte
    task automatic check_reg(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] got;
        logic       ok;
        u_acrb_host_model.rd_reg(a, got, ok);
        checks_done++;
        if (ok !== 1'b1) begin
            $display("[ERR] t=%0t read of %h timed out", $time, a);
            err_count++;
            finish_test();
        end else if (got !== exp) begin
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
            err_count++;
        end
    endtask : check_reg

    // compare an output level with the expected value
    task automatic check_out(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
            err_count++;
        end
    endtask : check_out

    // distance between the first two enable pulses within 20 cycles
    task automatic gap_of(output int gap);
        int first;
        first = -1;
        gap = 0;
        for (int i = 0; i < 20; i++) begin
            if (div_en === 1'b1) begin
                if (first < 0) begin
                    first = i;
                end else if (gap == 0) begin
                    gap = i - first;
                end
            end
            step(1);
        end
    endtask : gap_of

    // main sequence
    initial begin
        err_count = 0;
        checks_done = 0;
        rst_in = 1'b1;
        pwdn_pin = 1'b0;
        repeat (5) @(posedge clk_in);
        #1;
        rst_in = 1'b0;
        // reset values and idle outputs
        for (int i = 0; i < 8; i++) begin
            check_reg(RA[i], RV[i]);
        end
        check_out({7'h0, stab}, 8'h01);
        check_out({6'h0, pd}, 8'h00);
        check_out({7'h0, lsb}, 8'h00);
        // unmapped, read-only and open bits
        wr_reg(8'h03, 8'hA5);
        check_reg(8'h03, 8'h00);
        wr_reg(8'h01, 8'hFF);
        check_reg(8'h01, ID_VAL);
        wr_reg(8'h05, 8'hFD);
        check_reg(8'h05, 8'h01);
        // mirrored shift order from either nibble
        wr_reg(8'h00, 8'h40);
        check_reg(8'h00, 8'h5A);
        check_out({7'h0, lsb}, 8'h01);
        wr_reg(8'h00, 8'h18);
        wr_reg(8'h00, 8'h02);
        check_reg(8'h00, 8'h5A);
        wr_reg(8'h00, 8'h18);
        step(1);
        check_out({7'h0, lsb}, 8'h00);
        // per channel targets, shadowed until transfer
        wr_reg(8'h08, 8'h01);
        wr_reg(8'h05, 8'h02);
        wr_reg(8'h08, 8'h02);
        step(2);
        check_out({6'h0, pd}, 8'h00);
        wr_reg(8'hFF, 8'h01);
        check_reg(8'hFF, 8'h01);
        check_reg(8'hFF, 8'h00);
        check_out({6'h0, pd}, 8'h01);
        check_out({6'h0, sb}, 8'h02);
        check_reg(8'h08, 8'h02);
        wr_reg(8'h05, 8'h01);
        check_reg(8'h08, 8'h01);
        wr_reg(8'h05, 8'h03);
        check_reg(8'h08, 8'h01);
        // chip-wide register ignores channel select
        wr_reg(8'h05, 8'h00);
        wr_reg(8'h09, 8'h00);
        wr_reg(8'h05, 8'h01);
        check_reg(8'h09, 8'h00);
        wr_reg(8'hFF, 8'h00);
        step(2);
        check_out({7'h0, stab}, 8'h01);
        // every power mode code on both channels
        wr_reg(8'h05, 8'h03);
        for (int m = 0; m < 4; m++) begin
            wr_reg(8'h08, 8'(m));
            wr_reg(8'hFF, 8'h01);
            step(2);
            check_out({6'h0, pd}, (m == 1) ? 8'h03 : 8'h00);
            check_out({6'h0, sb}, (m == 2) ? 8'h03 : 8'h00);
        end
        check_out({7'h0, stab}, 8'h00);
        // pin function: power-down, then standby
        wr_reg(8'h08, 8'h00);
        wr_reg(8'hFF, 8'h01);
        pwdn_pin = 1'b1;
        step(4);
        check_out({6'h0, pd}, 8'h03);
        wr_reg(8'h08, 8'h20);
        wr_reg(8'hFF, 8'h01);
        step(2);
        check_out({6'h0, pd}, 8'h00);
        check_out({6'h0, sb}, 8'h03);
        pwdn_pin = 1'b0;
        step(4);
        check_out({6'h0, sb}, 8'h00);
        // every divide ratio, phase delay equal to the ratio code
        for (int r = 0; r < 8; r++) begin
            wr_reg(8'h0B, {2'h0, 3'(r), 3'(r)});
            check_reg(8'h0B, {2'h0, 3'(r), 3'(r)});
            wr_reg(8'hFF, 8'h01);
            step(16);
            gap_of(g);
            check_out(8'(g), 8'(r + 1));
            check_out({7'h0, stab}, (r != 0) ? 8'h01 : 8'h00);
        end
        // soft reset wins over shift order in the same write
        wr_reg(8'h05, 8'h01);
        wr_reg(8'h00, 8'h44);
        check_reg(8'h00, 8'h18);
        check_reg(8'h05, 8'h03);
        check_reg(8'h0B, 8'h00);
        check_reg(8'h09, 8'h01);
        check_out({7'h0, stab}, 8'h01);
        check_out({7'h0, lsb}, 8'h00);
        finish_test();
    end
endmodule : adc_config_register_bank_tb
`default_nettype wire
